// File: dv/ttd_ext_chain.sv
// external scan chain model on the far side of the block
`timescale 1ns/1ns
module ttd_ext_chain #(
    parameter int LEN = 5
) (
    input wire logic resetn_i, // async reset, low
    input wire logic tck_i, // test clock
    input wire logic [3:0] port_state_i, // port state
    input wire logic [3:0] chain_i, // active chain
    input wire logic ser_i, // stream from block
    output logic ser_o // stream back to block
);
    logic [LEN-1:0] cells_q;
    logic en_q;
    logic sel;
    // chain 3 and unassigned numbers, 4 and 8 reserved
    assign sel = chain_i == 4'h3 || (chain_i > 4'h4 && chain_i != 4'h8);
    // not selected: show the inverse of the last bit
    assign ser_o = sel ? cells_q[LEN-1] : ~cells_q[LEN-1];
    always_ff @(posedge tck_i or negedge resetn_i) begin
        if (!resetn_i)
            en_q <= 1'b0;
        else
            en_q <= sel && port_state_i == ttd_pkg::TAP_SHIFT_DR;
    end
    // shift after the fall, once the block has passed tdi on
    always_ff @(negedge tck_i or negedge resetn_i) begin
        if (!resetn_i)
            cells_q <= '0;
        else if (en_q)
            cells_q <= {cells_q[LEN-2:0], ser_i};
    end
endmodule : ttd_ext_chain

// File: dv/ttd_test_data_regs_bench.sv
// bench for the test data register block
`timescale 1ns/1ns
module ttd_test_data_regs_bench;
    logic clk = 0, rstn = 0, tck = 0, tms = 1, tdi = 0, trstn = 1;
    logic bprdy = 0, xi, to, toe;
    logic [137:0] normal = '0;
    logic tdo, oen, ph1, ph2, xo, bpv, bpr;
    logic [3:0] ach, cir, pst;
    logic [137:0] drive;
    logic [1:0] mode;
    logic [37:0] bpw;
    int failures = 0;
    int checks = 0;
    always #5 clk = ~clk;
    ttd_test_data_regs #(.ID_VERSION(4'h1), .ID_PART(16'h1234),
        .ID_MAKER(11'h055)) i_dut (.core_clk_i(clk), .resetn_i(rstn),
        .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trstn),
        .tdo_o(tdo), .tdo_oe_n_o(oen), .active_chain_number_out_o(ach),
        .current_instruction_out_o(cir), .port_state_out_o(pst),
        .test_clock_phase_one_o(ph1), .test_clock_phase_two_o(ph2),
        .ext_chain_serial_out_o(xo), .ext_chain_serial_in_i(xi),
        .cell_normal_i(normal), .cell_drive_o(drive), .scan_mode_o(mode),
        .bp_word_o(bpw), .bp_word_valid_o(bpv), .bp_word_ready_i(bprdy),
        .bp_fifo_ready_o(bpr));
    ttd_ext_chain #(.LEN(5)) i_chain (.resetn_i(rstn), .tck_i(tck),
        .port_state_i(pst), .chain_i(ach), .ser_i(xo), .ser_o(xi));
    task automatic chk(input string nm, input logic [127:0] s, e);
        checks++;
        if (s !== e) begin
            failures++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    // one tck period; tdo taken just before the rise
    task automatic tk(input logic m, d);
        tms = m;
        tdi = d;
        repeat (8) @(negedge clk);
        chk("phase", {ph1, ph2}, 2'b01);
        to = tdo;
        toe = oen;
        tck = 1'b1;
        repeat (8) @(negedge clk);
        chk("phase", {ph1, ph2}, 2'b10);
        tck = 1'b0;
    endtask : tk
    task automatic scan(input logic ir, input int n, input logic [127:0] di,
            output logic [127:0] dq);
        dq = '0;
        tk(1, 0);
        if (ir)
            tk(1, 0);
        tk(0, 0);
        tk(0, 0);
        for (int i = 0; i < n; i++) begin
            tk(i == n - 1, di[i]);
            dq[i] = to;
            chk("tdoen", toe, 1'b0);
        end
        tk(1, 0);
        tk(0, 0);
        repeat (4) @(negedge clk);
        chk("tdoen", oen, 1'b1);
    endtask : scan
    task automatic ldir(input logic [3:0] c);
        logic [127:0] q;
        scan(1, 4, c, q);
        chk("capir", q, 4'h1);
        chk("instr", cir, c);
    endtask : ldir
    task automatic pick(input logic [3:0] c);
        logic [127:0] q;
        ldir(4'h2);
        scan(0, 4, c, q);
        chk("capsel", q, 4'h8);
        chk("chain", ach, c);
    endtask : pick
    task automatic t_id;
        logic [127:0] q;
        chk("instr", cir, 4'hE);
        chk("chain", ach, 4'h0);
        tk(0, 0);
        scan(0, 32, '0, q);
        chk("idword", q, {4'h1, 16'h1234, 11'h055, 1'b1});
        $display("done id");
    endtask : t_id
    task automatic t_byp;
        logic [127:0] q;
        logic [3:0] codes [8] = '{4'hF, 4'h1, 4'h5, 4'h6, 4'h8, 4'hA, 4'hB,
            4'hD};
        foreach (codes[k]) begin
            ldir(codes[k]);
            scan(0, 8, 128'h00A5, q);
            chk("bypass", q, 8'h4A);
        end
        $display("done bypass");
    endtask : t_byp
    task automatic t_ext;
        logic [127:0] q;
        logic [3:0] chs [2] = '{4'h3, 4'h6};
        foreach (chs[k]) begin
            pick(chs[k]);
            ldir(k ? 4'h3 : 4'h0);
            scan(0, 16, 128'hC3A5, q);
            // five model cells delay the stream by five bits
            chk("extpath", q[15:5], 11'h3A5);
            ldir(4'hE);
            chk("chain", ach, chs[k]);
        end
        pick(4'h4);
        ldir(4'h0);
        scan(0, 8, 128'h00A5, q);
        chk("rsvchain", q, 8'h4A);
        $display("done external");
    endtask : t_ext
    task automatic t_chains;
        logic [127:0] q, m;
        int len, base;
        for (int c = 0; c < 2; c++) begin
            len = c ? 33 : 105;
            base = c ? 105 : 0;
            m = (128'h1 << len) - 1;
            pick(4'(c));
            ldir(4'h0);
            chk("mode", mode, 2'h2);
            ldir(4'hC);
            chk("mode", mode, 2'h1);
            scan(0, len + 8, '1, q);
            chk("length", q, ((128'h1 << (len + 8)) - 1) ^ m);
            chk("drive", 128'(drive >> base) & m, m);
        end
        ldir(4'hF);
        chk("mode", mode, 2'h0);
        $display("done chains");
    endtask : t_chains
    task automatic t_fifo;
        logic [127:0] q;
        pick(4'h2);
        ldir(4'hC);
        for (int k = 0; k < 9; k++) begin
            scan(0, 38, k + 1, q);
            chk("room", bpr, k < 7);
        end
        for (int k = 0; k < 8; k++) begin
            chk("valid", bpv, 1'b1);
            chk("word", bpw, k + 1);
            bprdy = 1'b1;
            @(negedge clk);
            bprdy = 1'b0;
            @(negedge clk);
        end
        chk("empty", bpv, 1'b0);
        $display("done fifo");
    endtask : t_fifo
    task automatic t_trst;
        trstn = 1'b0;
        repeat (4) @(negedge clk);
        trstn = 1'b1;
        repeat (4) @(negedge clk);
        chk("instr", cir, 4'hE);
        chk("chain", ach, 4'h0);
        tk(0, 0);
        pick(4'h1);
        ldir(4'hF);
        repeat (5) tk(1, 0);
        chk("state", pst, 4'h0);
        repeat (4) @(negedge clk);
        chk("instr", cir, 4'hE);
        chk("chain", ach, 4'h0);
        $display("done test reset");
    endtask : t_trst
    task automatic final_report;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        t_id();
        t_byp();
        t_ext();
        t_chains();
        t_fifo();
        t_trst();
        final_report();
    end
endmodule : ttd_test_data_regs_bench

// File: rtl/ttd_params.svh
// constants for the test data register block
`ifndef TTD_PARAMS_SVH
`define TTD_PARAMS_SVH
`define TTD_IR_W 4
`define TTD_SEL_W 4
`define TTD_ID_W 32
`define TTD_IR_EXTEST 4'h0
`define TTD_IR_SCAN_N 4'h2
`define TTD_IR_SAMPLE 4'h3
`define TTD_IR_RESTART 4'h4
`define TTD_IR_CLAMP 4'h5
`define TTD_IR_HIGHZ 4'h7
`define TTD_IR_CLAMPZ 4'h9
`define TTD_IR_INTEST 4'hC
`define TTD_IR_IDCODE 4'hE
`define TTD_IR_BYPASS 4'hF
`define TTD_IR_CAPTURE 4'h1
`define TTD_SEL_CAPTURE 4'h8
`define TTD_BYPASS_CAPTURE 1'b0
`define TTD_CHAIN_CORE 4'h0
`define TTD_CHAIN_DEBUG 4'h1
`define TTD_CHAIN_BPU 4'h2
`define TTD_CHAIN_EXT 4'h3
`define TTD_CHAIN_RSV_A 4'h4
`define TTD_CHAIN_RSV_B 4'h8
`define TTD_CHAIN_RESET 4'h0
`define TTD_CH0_LEN 105
`define TTD_CH1_LEN 33
`define TTD_CH2_LEN 38
`define TTD_ID_VER_MSB 31
`define TTD_ID_VER_LSB 28
`define TTD_ID_PART_MSB 27
`define TTD_ID_PART_LSB 12
`define TTD_ID_MAKER_MSB 11
`define TTD_ID_MAKER_LSB 1
`define TTD_ID_MARK_BIT 0
`define TTD_FIFO_DEPTH 8
`endif

// File: rtl/ttd_pkg.sv
// types shared by the test data register block
package ttd_pkg;
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR,
        TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
        TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } ttd_tap_state_t;
    typedef enum logic [2:0] {
        DR_BYPASS, DR_ID, DR_SEL, DR_CH0, DR_CH1, DR_CH2, DR_EXT
    } ttd_dr_t;
    typedef enum logic [1:0] {
        MODE_SYSTEM, MODE_INTEST, MODE_EXTEST
    } ttd_mode_t;
endpackage : ttd_pkg

// File: rtl/ttd_test_data_regs.sv
// test data registers, scan chains and word fifo behind the test port
`timescale 1ns/1ns
`include "ttd_params.svh"

module ttd_word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic core_clk_i, // core clock
    input wire logic resetn_i, // async reset, low
    input wire logic [WIDTH-1:0] in_data_i, // write data
    input wire logic in_valid_i, // write request
    output logic in_ready_o, // room left
    output logic [WIDTH-1:0] out_data_o, // head word
    output logic out_valid_o, // head valid
    input wire logic out_ready_i // reader takes head
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } ttd_fifo_st_t;
    ttd_fifo_st_t st_q, st_d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic push, pop;

    assign in_ready_o = (st_q.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (st_q.cnt != '0);
    assign out_data_o = mem_q[st_q.rd];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.wr = (st_q.wr == AW'(DEPTH-1)) ? '0 : st_q.wr + 1'b1;
        end
        if (pop) begin
            st_d.rd = (st_q.rd == AW'(DEPTH-1)) ? '0 : st_q.rd + 1'b1;
        end
        st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_q[st_q.wr] <= in_data_i;
        end
    end
endmodule : ttd_word_fifo

module ttd_test_data_regs #(
    parameter logic [3:0] ID_VERSION = 4'h1, // arbitrary value
    parameter logic [15:0] ID_PART = 16'h1234, // arbitrary value
    parameter logic [10:0] ID_MAKER = 11'h055, // arbitrary value
    parameter logic [`TTD_CH0_LEN+`TTD_CH1_LEN-1:0] OUT_CELLS = '0,
    parameter int FIFO_DEPTH = `TTD_FIFO_DEPTH
) (
    input wire logic core_clk_i, // core clock
    input wire logic resetn_i, // async reset, low
    input wire logic tck_i, // test clock pin
    input wire logic tms_i, // test mode select pin
    input wire logic tdi_i, // test data in pin
    input wire logic trst_n_i, // test reset pin, low
    output logic tdo_o, // test data out
    output logic tdo_oe_n_o, // tdo enable, low drives
    output logic [3:0] active_chain_number_out_o, // active chain
    output logic [3:0] current_instruction_out_o, // current instruction
    output logic [3:0] port_state_out_o, // port state
    output logic test_clock_phase_one_o, // tck high phase
    output logic test_clock_phase_two_o, // tck low phase
    output logic ext_chain_serial_out_o, // to external chain
    input wire logic ext_chain_serial_in_i, // from external chain
    input wire logic [`TTD_CH0_LEN+`TTD_CH1_LEN-1:0] cell_normal_i, // normal
    output logic [`TTD_CH0_LEN+`TTD_CH1_LEN-1:0] cell_drive_o, // onward
    output logic [1:0] scan_mode_o, // system, intest, extest
    output logic [`TTD_CH2_LEN-1:0] bp_word_o, // breakpoint word
    output logic bp_word_valid_o, // word waiting
    input wire logic bp_word_ready_i, // word taken
    output logic bp_fifo_ready_o // room for next word
);
    localparam int NC = `TTD_CH0_LEN + `TTD_CH1_LEN;
    localparam logic [`TTD_ID_W-1:0] ID_VALUE =
        {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

    typedef struct packed {
        logic [2:0] tck_s;
        logic [1:0] tms_s;
        logic [1:0] tdi_s;
        logic [1:0] trst_s;
        logic [1:0] ext_s;
        ttd_pkg::ttd_tap_state_t tap;
        logic [`TTD_IR_W-1:0] ir_shift;
        logic [`TTD_IR_W-1:0] ir;
        logic bypass;
        logic [`TTD_ID_W-1:0] id;
        logic [`TTD_SEL_W-1:0] sel;
        logic [`TTD_SEL_W-1:0] chain;
        logic [`TTD_CH0_LEN-1:0] ch0;
        logic [`TTD_CH1_LEN-1:0] ch1;
        logic [`TTD_CH2_LEN-1:0] ch2;
        logic ext_out;
        logic tdo;
        logic tdo_oe_n;
        logic push;
    } ttd_state_t;

    ttd_state_t st_q, st_d;
    logic rise, fall, tms, tdi, path_bit;
    ttd_pkg::ttd_dr_t dr;
    ttd_pkg::ttd_mode_t mode;

    assign rise = st_q.tck_s[1] && !st_q.tck_s[2];
    assign fall = !st_q.tck_s[1] && st_q.tck_s[2];
    assign tms = st_q.tms_s[1];
    assign tdi = st_q.tdi_s[1];

    // data register in the serial path for this instruction and chain
    always_comb begin
        dr = ttd_pkg::DR_BYPASS;
        case (st_q.ir)
            `TTD_IR_SCAN_N: dr = ttd_pkg::DR_SEL;
            `TTD_IR_IDCODE: dr = ttd_pkg::DR_ID;
            `TTD_IR_EXTEST, `TTD_IR_INTEST, `TTD_IR_SAMPLE: begin
                case (st_q.chain)
                    `TTD_CHAIN_CORE: dr = ttd_pkg::DR_CH0;
                    `TTD_CHAIN_DEBUG: dr = ttd_pkg::DR_CH1;
                    `TTD_CHAIN_BPU: dr = ttd_pkg::DR_CH2;
                    `TTD_CHAIN_RSV_A, `TTD_CHAIN_RSV_B: dr = ttd_pkg::DR_BYPASS;
                    default: dr = ttd_pkg::DR_EXT;
                endcase
            end
            default: dr = ttd_pkg::DR_BYPASS;
        endcase
    end

    always_comb begin
        case (st_q.ir)
            `TTD_IR_INTEST: mode = ttd_pkg::MODE_INTEST;
            `TTD_IR_EXTEST: mode = ttd_pkg::MODE_EXTEST;
            default: mode = ttd_pkg::MODE_SYSTEM;
        endcase
    end

    // bit presented to tdo: lsb of the active path
    always_comb begin
        path_bit = st_q.bypass;
        if (st_q.tap == ttd_pkg::TAP_SHIFT_IR) begin
            path_bit = st_q.ir_shift[0];
        end else begin
            case (dr)
                ttd_pkg::DR_ID: path_bit = st_q.id[0];
                ttd_pkg::DR_SEL: path_bit = st_q.sel[0];
                ttd_pkg::DR_CH0: path_bit = st_q.ch0[0];
                ttd_pkg::DR_CH1: path_bit = st_q.ch1[0];
                ttd_pkg::DR_CH2: path_bit = st_q.ch2[0];
                ttd_pkg::DR_EXT: path_bit = st_q.ext_s[1];
                default: path_bit = st_q.bypass;
            endcase
        end
    end

    always_comb begin
        st_d = st_q;
        st_d.tck_s = {st_q.tck_s[1:0], tck_i};
        st_d.tms_s = {st_q.tms_s[0], tms_i};
        st_d.tdi_s = {st_q.tdi_s[0], tdi_i};
        st_d.trst_s = {st_q.trst_s[0], trst_n_i};
        st_d.ext_s = {st_q.ext_s[0], ext_chain_serial_in_i};
        st_d.push = 1'b0;
        if (rise) begin
            case (st_q.tap)
                ttd_pkg::TAP_CAP_DR: begin
                    case (dr)
                        ttd_pkg::DR_BYPASS:
                            st_d.bypass = `TTD_BYPASS_CAPTURE;
                        ttd_pkg::DR_ID: st_d.id = ID_VALUE;
                        ttd_pkg::DR_SEL:
                            st_d.sel = `TTD_SEL_CAPTURE;
                        ttd_pkg::DR_CH0:
                            st_d.ch0 = cell_normal_i[`TTD_CH0_LEN-1:0];
                        ttd_pkg::DR_CH1:
                            st_d.ch1 = cell_normal_i[NC-1:`TTD_CH0_LEN];
                        default: st_d.push = 1'b0;
                    endcase
                end
                ttd_pkg::TAP_SHIFT_DR: begin
                    case (dr)
                        ttd_pkg::DR_ID: st_d.id = {tdi, st_q.id[31:1]};
                        ttd_pkg::DR_SEL:
                            st_d.sel = {tdi, st_q.sel[3:1]};
                        ttd_pkg::DR_CH0: st_d.ch0 =
                            {tdi, st_q.ch0[`TTD_CH0_LEN-1:1]};
                        ttd_pkg::DR_CH1: st_d.ch1 =
                            {tdi, st_q.ch1[`TTD_CH1_LEN-1:1]};
                        ttd_pkg::DR_CH2:
                            st_d.ch2 = {tdi, st_q.ch2[`TTD_CH2_LEN-1:1]};
                        ttd_pkg::DR_EXT: st_d.ext_out = tdi;
                        default: st_d.bypass = tdi;
                    endcase
                end
                ttd_pkg::TAP_UPD_DR: begin
                    if (dr == ttd_pkg::DR_SEL) begin
                        st_d.chain = st_q.sel;
                    end
                    // full fifo drops the word; see bp_fifo_ready_o
                    st_d.push = (dr == ttd_pkg::DR_CH2)
                        && (st_q.ir == `TTD_IR_INTEST);
                end
                ttd_pkg::TAP_CAP_IR: st_d.ir_shift = `TTD_IR_CAPTURE;
                ttd_pkg::TAP_SHIFT_IR:
                    st_d.ir_shift = {tdi, st_q.ir_shift[3:1]};
                ttd_pkg::TAP_UPD_IR: st_d.ir = st_q.ir_shift;
                default: st_d.push = 1'b0;
            endcase
            case (st_q.tap)
                ttd_pkg::TAP_RESET: st_d.tap = tms ? ttd_pkg::TAP_RESET
                                                   : ttd_pkg::TAP_IDLE;
                ttd_pkg::TAP_IDLE: st_d.tap = tms ? ttd_pkg::TAP_SEL_DR
                                                  : ttd_pkg::TAP_IDLE;
                ttd_pkg::TAP_SEL_DR: st_d.tap = tms ? ttd_pkg::TAP_SEL_IR
                                                    : ttd_pkg::TAP_CAP_DR;
                ttd_pkg::TAP_CAP_DR, ttd_pkg::TAP_SHIFT_DR:
                    st_d.tap = tms ? ttd_pkg::TAP_EXIT1_DR
                                   : ttd_pkg::TAP_SHIFT_DR;
                ttd_pkg::TAP_EXIT1_DR: st_d.tap = tms ? ttd_pkg::TAP_UPD_DR
                                                      : ttd_pkg::TAP_PAUSE_DR;
                ttd_pkg::TAP_PAUSE_DR: st_d.tap = tms ? ttd_pkg::TAP_EXIT2_DR
                                                      : ttd_pkg::TAP_PAUSE_DR;
                ttd_pkg::TAP_EXIT2_DR: st_d.tap = tms ? ttd_pkg::TAP_UPD_DR
                                                      : ttd_pkg::TAP_SHIFT_DR;
                ttd_pkg::TAP_UPD_DR, ttd_pkg::TAP_UPD_IR:
                    st_d.tap = tms ? ttd_pkg::TAP_SEL_DR : ttd_pkg::TAP_IDLE;
                ttd_pkg::TAP_SEL_IR: st_d.tap = tms ? ttd_pkg::TAP_RESET
                                                    : ttd_pkg::TAP_CAP_IR;
                ttd_pkg::TAP_CAP_IR, ttd_pkg::TAP_SHIFT_IR:
                    st_d.tap = tms ? ttd_pkg::TAP_EXIT1_IR
                                   : ttd_pkg::TAP_SHIFT_IR;
                ttd_pkg::TAP_EXIT1_IR: st_d.tap = tms ? ttd_pkg::TAP_UPD_IR
                                                      : ttd_pkg::TAP_PAUSE_IR;
                ttd_pkg::TAP_PAUSE_IR: st_d.tap = tms ? ttd_pkg::TAP_EXIT2_IR
                                                      : ttd_pkg::TAP_PAUSE_IR;
                ttd_pkg::TAP_EXIT2_IR: st_d.tap = tms ? ttd_pkg::TAP_UPD_IR
                                                      : ttd_pkg::TAP_SHIFT_IR;
                default: st_d.tap = ttd_pkg::TAP_RESET;
            endcase
        end
        if (fall) begin
            st_d.tdo = path_bit;
            st_d.tdo_oe_n = !((st_q.tap == ttd_pkg::TAP_SHIFT_DR)
                || (st_q.tap == ttd_pkg::TAP_SHIFT_IR));
        end
        if (!st_q.trst_s[1]) begin
            st_d.tap = ttd_pkg::TAP_RESET;
        end
        if (st_q.tap == ttd_pkg::TAP_RESET) begin
            st_d.ir = `TTD_IR_IDCODE;
            st_d.chain = `TTD_CHAIN_RESET;
            st_d.tdo_oe_n = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= '0;
            st_q.tap <= ttd_pkg::TAP_RESET;
            st_q.ir <= `TTD_IR_IDCODE;
            st_q.ir_shift <= `TTD_IR_CAPTURE;
            st_q.chain <= `TTD_CHAIN_RESET;
            st_q.tdo_oe_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // no update latch: drives follow the serial stage while shifting
    genvar gi;
    generate
        for (gi = 0; gi < NC; gi++) begin : g_cell
            logic stage;
            logic test;
            if (gi < `TTD_CH0_LEN) begin : g_c0
                assign stage = st_q.ch0[gi];
            end else begin : g_c1
                assign stage = st_q.ch1[gi-`TTD_CH0_LEN];
            end
            assign test = OUT_CELLS[gi] ? (mode == ttd_pkg::MODE_EXTEST)
                                        : (mode == ttd_pkg::MODE_INTEST);
            assign cell_drive_o[gi] = test ? stage
                                           : cell_normal_i[gi];
        end
    endgenerate

    ttd_word_fifo #(
        .WIDTH(`TTD_CH2_LEN),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .in_data_i(st_q.ch2),
        .in_valid_i(st_q.push),
        .in_ready_o(bp_fifo_ready_o),
        .out_data_o(bp_word_o),
        .out_valid_o(bp_word_valid_o),
        .out_ready_i(bp_word_ready_i)
    );

    assign tdo_o = st_q.tdo;
    assign tdo_oe_n_o = st_q.tdo_oe_n;
    assign active_chain_number_out_o = st_q.chain;
    assign current_instruction_out_o = st_q.ir;
    assign port_state_out_o = 4'(st_q.tap);
    assign test_clock_phase_one_o = st_q.tck_s[2];
    assign test_clock_phase_two_o = !st_q.tck_s[2];
    assign ext_chain_serial_out_o = st_q.ext_out;
    assign scan_mode_o = 2'(mode);

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    a_bypass_capture: assert property (rise && dr == ttd_pkg::DR_BYPASS
        && st_q.tap == ttd_pkg::TAP_CAP_DR |=> !st_q.bypass)
        else $error("bypass stage did not capture zero");
    a_bypass_shift: assert property (rise && dr == ttd_pkg::DR_BYPASS
        && st_q.tap == ttd_pkg::TAP_SHIFT_DR
        |=> st_q.bypass == $past(tdi))
        else $error("bypass stage did not take tdi");
    a_id_capture: assert property (rise && dr == ttd_pkg::DR_ID
        && st_q.tap == ttd_pkg::TAP_CAP_DR
        |=> st_q.id == ID_VALUE && st_q.id[0])
        else $error("id word not captured");
    a_ir_capture: assert property (rise
        && st_q.tap == ttd_pkg::TAP_CAP_IR
        |=> st_q.ir_shift == 4'h1)
        else $error("instruction capture pattern wrong");
    a_ir_update: assert property (rise && st_q.tap == ttd_pkg::TAP_UPD_IR
        && st_q.trst_s[1] |=> st_q.ir == $past(st_q.ir_shift))
        else $error("instruction not adopted at update");
    a_sel_capture: assert property (rise && dr == ttd_pkg::DR_SEL
        && st_q.tap == ttd_pkg::TAP_CAP_DR
        |=> st_q.sel == 4'h8)
        else $error("chain select capture pattern wrong");
    a_chain_hold: assert property (!(rise && dr == ttd_pkg::DR_SEL
        && st_q.tap == ttd_pkg::TAP_UPD_DR)
        && st_q.tap != ttd_pkg::TAP_RESET
        |=> $stable(st_q.chain))
        else $error("active chain changed without update");
    a_reset_defaults: assert property (st_q.tap == ttd_pkg::TAP_RESET
        |=> st_q.ir == 4'hE && st_q.chain == 4'h0)
        else $error("test reset defaults missing");
    a_tdo_on_fall: assert property ($changed(st_q.tdo)
        |-> $past(fall))
        else $error("tdo moved away from a falling tck");
    a_ext_route: assert property (dr == ttd_pkg::DR_EXT
        && st_q.tap == ttd_pkg::TAP_SHIFT_DR && fall
        |=> st_q.tdo == $past(st_q.ext_s[1]))
        else $error("external chain not on tdo");

    c_scan_select: cover property (rise && dr == ttd_pkg::DR_SEL
        && st_q.tap == ttd_pkg::TAP_UPD_DR);
    c_id_shift: cover property (rise && dr == ttd_pkg::DR_ID
        && st_q.tap == ttd_pkg::TAP_SHIFT_DR);
    c_ext_shift: cover property (rise && dr == ttd_pkg::DR_EXT
        && st_q.tap == ttd_pkg::TAP_SHIFT_DR);
    c_word_push: cover property (st_q.push && bp_fifo_ready_o);
endmodule : ttd_test_data_regs
